/* File: pac_adc_ctrl.sv */
// Conversion sequencing of a 10-bit successive-approximation converter.
// Assumes strobes and the external clock are asynchronous pins; the analog
// comparator is modelled by a sampled digital input word and range flags.
//
// Functional notes
// - Write and read strobes are ignored unless chip select is low.
// - A write with chip select low starts a conversion from the track state.
// - The block tracks from the end of conversion, as the done flag falls, until write rises.
// - The rising write edge freezes the sample and enters hold.
// - After hold the clock runs the whole approximation unaided.
// - At the end the result is latched and the done flag goes low.
// - A selected read clears the done flag and drives the result.
// - Data outputs drive only during a read and release after it.
// - Inputs above or below the references give all ones or zeros.
// - With the internal clock a conversion finishes within the documented conversion time.
`timescale 1ns/100ps
module pac_adc_ctrl #(
   parameter int DATA_W = pac_pkg::DATA_W
) (
   // System
   input  wire logic              clk,
   input  wire logic              rstn,
   // Host strobes (pins)
   input  wire logic              csN,
   input  wire logic              wrN,
   input  wire logic              rdN,
   // Clock selection and external clock pin
   input  wire logic              extClkEn,
   input  wire logic              external_clock_in,
   // Analog front end model
   input  wire logic [DATA_W-1:0] analogIn,
   input  wire logic              aboveRef,
   input  wire logic              belowRef,
   // Outputs
   output logic [DATA_W-1:0]      dataOut,
   output logic                   dataOe,
   output logic                   eocN,
   output logic                   tracking
);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic [4:0] s1_reg, s2_reg, s3_reg;
   logic       csS, wrS, rdS, ckS, wrRise, rdFall, rdRise, ckRise;

   always_ff @(posedge clk or negedge rstn) begin
      // Reset values match the idle pin levels, so no false edge follows.
      if (!rstn) begin
         s1_reg <= 5'h1C;
         s2_reg <= 5'h1C;
         s3_reg <= 5'h1C;
      end else begin
         s1_reg <= {csN, wrN, rdN, external_clock_in, extClkEn};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign csS    = ~s2_reg[4];
   assign wrS    = ~s2_reg[3];
   assign rdS    = ~s2_reg[2];
   assign ckS    = s2_reg[1];
   // Chip select is taken from the sample before the write edge so a late select
   // cannot launch a stray conversion.
   assign wrRise = s2_reg[3] & ~s3_reg[3] & ~s3_reg[4];
   assign rdFall = rdS & s3_reg[2] & csS;
   assign rdRise = s2_reg[2] & ~s3_reg[2];
   assign ckRise = ckS & ~s3_reg[1];

   // -------------------------------------------------------------------
   // Bit clock: internal divider or external clock edges
   // -------------------------------------------------------------------
   logic [15:0] div_reg, div_next;
   logic        intTick, bitTick;

   always_comb begin
      div_next = div_reg + 16'h0001;
      intTick  = (div_reg == 16'(pac_pkg::INT_DIV - 1));
      if (intTick) begin
         div_next = 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 16'h0000;
      end else begin
         div_reg <= div_next;
      end
   end

   assign bitTick = s2_reg[0] ? ckRise : intTick;

   // -------------------------------------------------------------------
   // Conversion sequencer
   // -------------------------------------------------------------------
   pac_pkg::pac_state_t state_reg, state_next;
   logic [DATA_W-1:0]   hold_reg, hold_next;
   logic [DATA_W-1:0]   sar_reg, sar_next;
   logic [DATA_W-1:0]   mask_reg, mask_next;
   logic [DATA_W-1:0]   res_reg, res_next;
   logic [1:0]          rng_reg, rng_next;
   logic                eoc_reg, eoc_next;
   logic [DATA_W-1:0]   trial;

   always_comb begin
      state_next = state_reg;
      hold_next  = hold_reg;
      sar_next   = sar_reg;
      mask_next  = mask_reg;
      res_next   = res_reg;
      rng_next   = rng_reg;
      eoc_next   = eoc_reg;
      trial      = sar_reg | mask_reg;
      // A read clears the done flag; a conversion that ends in the same
      // cycle sets it again below, so a fresh result is never missed.
      if (rdFall) begin
         eoc_next = 1'b1;
      end
      unique case (state_reg)
         pac_pkg::PAC_TRACK: begin
            if (wrRise) begin
               hold_next  = analogIn;
               rng_next   = {aboveRef, belowRef};
               state_next = pac_pkg::PAC_HOLD;
            end
         end
         pac_pkg::PAC_HOLD: begin
            sar_next   = '0;
            mask_next  = {1'b1, {(DATA_W-1){1'b0}}};
            state_next = pac_pkg::PAC_CONV;
         end
         pac_pkg::PAC_CONV: begin
            if (bitTick) begin
               if (mask_reg == '0) begin
                  if (rng_reg[1]) begin
                     res_next = pac_pkg::CODE_ALL_ONES;
                  end else if (rng_reg[0]) begin
                     res_next = pac_pkg::CODE_ALL_ZEROS;
                  end else begin
                     res_next = sar_reg;
                  end
                  eoc_next   = 1'b0;
                  state_next = pac_pkg::PAC_TRACK;
               end else begin
                  if (trial <= hold_reg) begin
                     sar_next = trial;
                  end
                  mask_next = mask_reg >> 1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= pac_pkg::PAC_TRACK;
         hold_reg  <= '0;
         sar_reg   <= '0;
         mask_reg  <= '0;
         res_reg   <= pac_pkg::DATA_RESET;
         rng_reg   <= 2'b00;
         eoc_reg   <= 1'b1;
      end else begin
         state_reg <= state_next;
         hold_reg  <= hold_next;
         sar_reg   <= sar_next;
         mask_reg  <= mask_next;
         res_reg   <= res_next;
         rng_reg   <= rng_next;
         eoc_reg   <= eoc_next;
      end
   end

   // -------------------------------------------------------------------
   // Data bus drive
   // -------------------------------------------------------------------
   // The bus follows the synchronised strobes, so it lags the pins.
   pac_pkg::pac_bus_t bus_reg, bus_next;

   always_comb begin
      bus_next = bus_reg;
      if (csS && rdS) begin
         bus_next.data   = res_reg;
         bus_next.dataOe = 1'b1;
      end else begin
         bus_next.dataOe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_reg <= '{data: pac_pkg::DATA_RESET, dataOe: 1'b0};
      end else begin
         bus_reg <= bus_next;
      end
   end

   // The tracking flag is registered from the next state so that it
   // moves in the same cycle as the state itself.
   logic trk_reg, trk_next;

   always_comb begin
      trk_next = (state_next == pac_pkg::PAC_TRACK);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trk_reg <= 1'b1;
      end else begin
         trk_reg <= trk_next;
      end
   end

   assign dataOut  = bus_reg.data;
   assign dataOe   = bus_reg.dataOe;
   assign eocN     = eoc_reg;
   assign tracking = trk_reg;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   // Cycles spent out of track in the current conversion.
   int unsigned convCnt_reg, convCnt_next;

   always_comb begin
      convCnt_next = convCnt_reg + 1;
      if (state_reg == pac_pkg::PAC_TRACK) begin
         convCnt_next = 0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         convCnt_reg <= 0;
      end else begin
         convCnt_reg <= convCnt_next;
      end
   end

   sequence s_start;
      state_reg == pac_pkg::PAC_TRACK && wrRise;
   endsequence
   sequence s_held;
      state_reg == pac_pkg::PAC_HOLD ##1 state_reg == pac_pkg::PAC_CONV;
   endsequence
   // One approximation step halves the trial mask; the last one latches.
   sequence s_step;
      state_reg == pac_pkg::PAC_CONV && bitTick && mask_reg != '0;
   endsequence
   sequence s_last;
      state_reg == pac_pkg::PAC_CONV && bitTick && mask_reg == '0;
   endsequence

   a_write_starts: assert property (@(posedge clk) disable iff (!rstn)
      s_start |=> s_held) else $error("write did not start conversion");
   a_no_sel_write: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == pac_pkg::PAC_TRACK && !wrRise) |=>
      state_reg == pac_pkg::PAC_TRACK) else $error("unselected start");
   a_no_sel_read: assert property (@(posedge clk) disable iff (!rstn)
      !csS |=> !dataOe) else $error("unselected read drove bus");
   a_sample_taken: assert property (@(posedge clk) disable iff (!rstn)
      s_start |=> hold_reg == $past(analogIn))
      else $error("sample not captured");
   a_hold_frozen: assert property (@(posedge clk) disable iff (!rstn)
      state_reg != pac_pkg::PAC_TRACK && $past(state_reg)
      != pac_pkg::PAC_TRACK |-> $stable(hold_reg))
      else $error("sample moved in hold");
   a_bit_steps: assert property (@(posedge clk) disable iff (!rstn)
      s_step |=> mask_reg == ($past(mask_reg) >> 1))
      else $error("approximation step skipped");
   a_conv_bound: assert property (@(posedge clk) disable iff (!rstn)
      s2_reg[0] == 1'b0 |-> convCnt_reg <= pac_pkg::CONV_MAX_CYC)
      else $error("conversion too long");
   a_eoc_falls: assert property (@(posedge clk) disable iff (!rstn)
      (state_reg == pac_pkg::PAC_CONV && state_next == pac_pkg::PAC_TRACK
      && !rdFall) |=> !eocN && tracking) else $error("done flag missing");
   a_eoc_stands: assert property (@(posedge clk) disable iff (!rstn)
      !eocN && !rdFall |=> !eocN) else $error("done flag dropped early");
   a_read_clears: assert property (@(posedge clk) disable iff (!rstn)
      rdFall && !(state_reg == pac_pkg::PAC_CONV &&
      state_next == pac_pkg::PAC_TRACK) |=> eocN)
      else $error("read did not clear flag");
   a_bus_idle: assert property (@(posedge clk) disable iff (!rstn)
      !rdS |=> !dataOe) else $error("bus driven outside read");
   a_sar_result: assert property (@(posedge clk) disable iff (!rstn)
      s_last ##0 rng_reg == 2'b00 |=> res_reg == hold_reg)
      else $error("result differs from sample");
   a_ext_only: assert property (@(posedge clk) disable iff (!rstn)
      s2_reg[0] && state_reg == pac_pkg::PAC_CONV && !ckRise |=>
      mask_reg == $past(mask_reg) && state_reg == pac_pkg::PAC_CONV)
      else $error("step without external clock");
   a_bottom_code: assert property (@(posedge clk) disable iff (!rstn)
      s_last ##0 rng_reg == 2'b01 |=> res_reg == pac_pkg::CODE_ALL_ZEROS)
      else $error("under range code wrong");
   a_bus_release: assert property (@(posedge clk) disable iff (!rstn)
      rdRise |=> !dataOe) else $error("bus still driven");
   a_bus_data: assert property (@(posedge clk) disable iff (!rstn)
      csS && rdS |=> dataOe && dataOut == $past(res_reg))
      else $error("wrong read data");
   a_top_code: assert property (@(posedge clk) disable iff (!rstn)
      state_reg == pac_pkg::PAC_CONV && bitTick && mask_reg == '0 &&
      rng_reg[1] |=> res_reg == pac_pkg::CODE_ALL_ONES)
      else $error("over range code wrong");
   a_track_until: assert property (@(posedge clk) disable iff (!rstn)
      $rose(eocN) && state_reg == pac_pkg::PAC_TRACK && !wrRise |=>
      tracking && state_reg == pac_pkg::PAC_TRACK)
      else $error("left track early");

endmodule

/* File: pac_host_model.sv */
// Processor bus model that reaches the converter like a memory location.
// Assumes the bench calls its tasks; strobes change on falling clock edges.
`timescale 1ns/100ps
module pac_host_model (
   // System
   input  wire logic       clk,
   // Strobes
   output logic            csN,
   output logic            wrN,
   output logic            rdN,
   // Data bus
   input  wire logic [9:0] dataOut,
   input  wire logic       dataOe
);
   logic [9:0] lastBus = 10'h000;
   logic [9:0] busVal;

   // A released bus has no pull, so it shows a value that keeps changing.
   assign busVal = dataOe ? dataOut : ~lastBus;
   always @(posedge clk) lastBus <= busVal;

   initial begin
      csN = 1'b1;
      wrN = 1'b1;
      rdN = 1'b1;
   end

   // Each strobe pulse is held 10 cycles (50 ns) inside the select frame.
   task automatic write_cycle(input logic sel);
      @(negedge clk);
      csN = ~sel;
      @(negedge clk);
      wrN = 1'b0;
      repeat (10) @(negedge clk);
      wrN = 1'b1;
      @(negedge clk);
      csN = 1'b1;
   endtask

   task automatic read_cycle(input logic sel, output logic [9:0] d);
      @(negedge clk);
      csN = ~sel;
      @(negedge clk);
      rdN = 1'b0;
      repeat (10) @(posedge clk);
      d = busVal;
      @(negedge clk);
      rdN = 1'b1;
      @(negedge clk);
      csN = 1'b1;
   endtask
endmodule

/* File: pac_pkg.sv */
// Shared constants and carriers for the parallel converter control block.
// Assumes a single 200 MHz system clock.
package pac_pkg;

   // -------------------------------------------------------------------
   // Widths and timing
   // -------------------------------------------------------------------
   localparam int          DATA_W         = 10;
   localparam int          CLK_MHZ        = 200;
   localparam int          CONV_TIME_NS   = 6000;
   localparam int          CONV_MAX_CYC   = (CONV_TIME_NS * CLK_MHZ) / 1000;
   localparam int          BIT_STEPS      = DATA_W + 1;
   localparam int          INT_DIV        = CONV_MAX_CYC / (BIT_STEPS + 1);
   localparam logic [9:0]  CODE_ALL_ONES  = 10'h3FF;
   localparam logic [9:0]  CODE_ALL_ZEROS = 10'h000;
   localparam logic [9:0]  DATA_RESET     = 10'h000;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      PAC_TRACK = 3'b001,
      PAC_HOLD  = 3'b010,
      PAC_CONV  = 3'b100
   } pac_state_t;

   typedef struct packed {
      logic [9:0] data;
      logic       dataOe;
   } pac_bus_t;

endpackage

/* File: testbench.sv */
// Self-checking bench for the converter control block.
// Assumes the host model file is compiled before this one.
`timescale 1ns/100ps
module testbench;
   logic       clk      = 1'b0;
   logic       rstn     = 1'b0;
   logic       extClk   = 1'b0;
   logic       extRun   = 1'b0;
   logic       oeSeen   = 1'b0;
   logic       csN;
   logic       wrN;
   logic       rdN;
   logic       extClkEn;
   logic [9:0] analogIn;
   logic       aboveRef;
   logic       belowRef;
   logic [9:0] dataOut;
   logic       dataOe;
   logic       eocN;
   logic       tracking;
   int         errors     = 0;
   int         checksDone = 0;
   int         cycles     = 0;

   always #2.5 clk = ~clk;
   // External clock at 4.2 MHz, still outside its test.
   always #119 extClk = extRun ? ~extClk : 1'b0;
   always @(posedge clk) if (dataOe === 1'b1) oeSeen <= 1'b1;

   pac_adc_ctrl uut (.clk(clk), .rstn(rstn), .csN(csN), .wrN(wrN),
      .rdN(rdN), .extClkEn(extClkEn), .external_clock_in(extClk),
      .analogIn(analogIn), .aboveRef(aboveRef), .belowRef(belowRef),
      .dataOut(dataOut), .dataOe(dataOe), .eocN(eocN),
      .tracking(tracking));

   pac_host_model host (.clk(clk), .csN(csN), .wrN(wrN), .rdN(rdN),
      .dataOut(dataOut), .dataOe(dataOe));

   task automatic end_of_test();
      $display("checks %0d errors %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic check(input logic [9:0] seen, input logic [9:0] exp,
                        input string what);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   // Starts a conversion, retries the write mid-way, then reads the word.
   task automatic do_conv(input logic [9:0] late, output logic [9:0] d);
      int cyc;
      host.write_cycle(1'b1);
      // The sample is taken three cycles after the pin edge; move later.
      repeat (4) @(negedge clk);
      analogIn = late;
      host.write_cycle(1'b1);
      cyc = 18;
      check({9'h000, tracking}, 10'h000, "hold");
      while (eocN !== 1'b0 && cyc < 1300) begin
         @(negedge clk);
         cyc++;
      end
      check({9'h000, cyc <= pac_pkg::CONV_MAX_CYC}, 10'h001, "time");
      host.read_cycle(1'b1, d);
      check({9'h000, eocN}, 10'h001, "eoc clear");
      repeat (4) @(negedge clk);
      check({9'h000, dataOe}, 10'h000, "release");
      check({9'h000, tracking}, 10'h001, "track");
   endtask

   task automatic t_basic();
      logic [9:0] d;
      analogIn = 10'h2A5;
      do_conv(10'h15A, d);
      check(d, 10'h2A5, "result");
      $display("t_basic done");
   endtask

   task automatic t_no_cs();
      logic [9:0] d;
      host.write_cycle(1'b1);
      repeat (1200) @(negedge clk);
      check({9'h000, eocN}, 10'h000, "done");
      oeSeen = 1'b0;
      host.write_cycle(1'b0);
      host.read_cycle(1'b0, d);
      repeat (20) @(negedge clk);
      check({9'h000, eocN}, 10'h000, "no clear");
      check({9'h000, tracking}, 10'h001, "no hold");
      check({9'h000, oeSeen}, 10'h000, "no drive");
      host.read_cycle(1'b1, d);
      check(d, 10'h15A, "latched");
      $display("t_no_cs done");
   endtask

   task automatic t_range();
      logic [9:0] d;
      for (int i = 0; i < 2; i++) begin
         aboveRef = (i == 0);
         belowRef = (i == 1);
         do_conv(10'h1F0, d);
         check(d, i == 0 ? pac_pkg::CODE_ALL_ONES
                         : pac_pkg::CODE_ALL_ZEROS, "range");
      end
      aboveRef = 1'b0;
      belowRef = 1'b0;
      $display("t_range done");
   endtask

   task automatic t_ext();
      logic [9:0] d;
      extClkEn = 1'b1;
      extRun = 1'b1;
      analogIn = 10'h0C3;
      do_conv(10'h3C0, d);
      check(d, 10'h0C3, "ext result");
      extRun = 1'b0;
      extClkEn = 1'b0;
      $display("t_ext done");
   endtask

   initial begin
      extClkEn = 1'b0;
      analogIn = 10'h000;
      aboveRef = 1'b0;
      belowRef = 1'b0;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      t_basic();
      t_no_cs();
      t_range();
      t_ext();
      end_of_test();
   end
endmodule
